// [rtl/crxh_pkg.sv]
// crxh_pkg: constants for the receive buffer header storage.
// assumes byte-wide registers on a byte-addressed Avalon-MM slave.
package crxh_pkg;
	// register offsets (byte addresses)
	localparam logic [7:0] RX0_STD_ID_HIGH = 8'h61;
	localparam logic [7:0] RX0_STD_ID_LOW  = 8'h62;
	localparam logic [7:0] RX0_EXT_ID_HIGH = 8'h63;
	localparam logic [7:0] RX0_EXT_ID_LOW  = 8'h64;
	localparam logic [7:0] RX0_LENGTH_CODE = 8'h65;
	localparam logic [7:0] RX1_STD_ID_HIGH = 8'h71;
	localparam logic [7:0] RX1_STD_ID_LOW  = 8'h72;
	localparam logic [7:0] RX1_EXT_ID_HIGH = 8'h73;
	localparam logic [7:0] RX1_EXT_ID_LOW  = 8'h74;
	localparam logic [7:0] RX1_LENGTH_CODE = 8'h75;
	localparam logic [7:0] BUF_STRIDE      = 8'h10;
	// field positions in the identifier low register
	localparam int STDLO_ID_LSB  = 5;
	localparam int STDLO_RMT_BIT = 4;
	localparam int STDLO_EXT_BIT = 3;
	// field positions in the length code register
	localparam int LEN_RMT_BIT    = 6;
	localparam int LEN_RSV_HI_BIT = 5;
	localparam int LEN_RSV_LO_BIT = 4;
	// reset values
	localparam logic [10:0] STD_ID_RST = 11'h000;
	localparam logic [17:0] EXT_ID_RST = 18'h00000;
	localparam logic [3:0]  DLC_RST    = 4'h0;
	localparam logic [7:0]  RDATA_RST  = 8'h00;
endpackage : crxh_pkg

// [rtl/crxh_slot.sv]
// crxh_slot: header storage for one receive buffer.
// assumes load is a one-cycle pulse from the receive path.
`timescale 1ns/1ns
`default_nettype none
module crxh_slot (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	input  wire logic        load,
	input  wire logic [10:0] standard_identifier,
	input  wire logic [17:0] extended_identifier,
	input  wire logic        ide,
	input  wire logic        rtr,
	input  wire logic        reserved_ctrl_hi,
	input  wire logic        reserved_ctrl_lo,
	input  wire logic [3:0]  dlc,
	output logic      [7:0]  std_high,
	output logic      [7:0]  std_low,
	output logic      [7:0]  ext_high,
	output logic      [7:0]  ext_low,
	output logic      [7:0]  len_code
);
	typedef struct packed {
		logic [10:0] std_id;
		logic [17:0] ext_id;
		logic        ide;
		logic        rtr;
		logic        rsv_hi;
		logic        rsv_lo;
		logic [3:0]  dlc;
	} crxh_slot_t;

	crxh_slot_t st_q, st_d;

	// capture header on an accepted frame
	always_comb begin
		st_d = st_q;
		if (load) begin
			st_d.std_id = standard_identifier;
			st_d.ext_id = extended_identifier;
			st_d.ide = ide;
			st_d.rtr = rtr;
			st_d.rsv_hi = reserved_ctrl_hi;
			st_d.rsv_lo = reserved_ctrl_lo;
			st_d.dlc = dlc;
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '{std_id: crxh_pkg::STD_ID_RST, ext_id: crxh_pkg::EXT_ID_RST,
				ide: 1'b0, rtr: 1'b0, rsv_hi: 1'b0, rsv_lo: 1'b0, dlc: crxh_pkg::DLC_RST};
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	// register views
	always_comb begin
		std_high = st_q.std_id[10:3];
		std_low  = 8'h00;
		std_low[7:crxh_pkg::STDLO_ID_LSB] = st_q.std_id[2:0];
		std_low[crxh_pkg::STDLO_RMT_BIT] = ~st_q.ide & st_q.rtr;
		std_low[crxh_pkg::STDLO_EXT_BIT] = st_q.ide;
		std_low[1:0] = st_q.ext_id[17:16];
		ext_high = st_q.ext_id[15:8];
		ext_low  = st_q.ext_id[7:0];
		len_code = 8'h00;
		len_code[crxh_pkg::LEN_RMT_BIT] = st_q.ide & st_q.rtr;
		len_code[crxh_pkg::LEN_RSV_HI_BIT] = st_q.rsv_hi;
		len_code[crxh_pkg::LEN_RSV_LO_BIT] = st_q.rsv_lo;
		len_code[3:0] = st_q.dlc;
	end
endmodule : crxh_slot
`default_nettype wire

// [rtl/crxh_top.sv]
// crxh_top: read-only receive buffer headers behind an Avalon-MM slave.
// assumes the receive path pulses load_buf0/1 once per accepted frame.
// Functional notes
// - two buffers, five read-only header registers each
// - std id high holds identifier bits 10:3
// - std id low bits 7:5 hold id 2:0
// - std low bit 4 flags standard remote
// - std low bit 3 flags extended format
// - unused bits read as zero
// - std low bits 1:0 hold ext id 17:16
// - ext id high holds ext bits 15:8
// - ext id low holds ext bits 7:0
// - length code bits 3:0 give byte count
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module crxh_top (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [7:0]  avs_writedata,
	output logic      [7:0]  avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        load_buf0,
	input  wire logic        load_buf1,
	input  wire logic [10:0] standard_identifier,
	input  wire logic [17:0] extended_identifier,
	input  wire logic        ide,
	input  wire logic        rtr,
	input  wire logic        reserved_ctrl_hi,
	input  wire logic        reserved_ctrl_lo,
	input  wire logic [3:0]  dlc,
	output logic             buf0_loaded,
	output logic             buf1_loaded
);
	typedef struct packed {
		logic [7:0] rdata;
		logic       wait_n;
		logic       ack;
		logic       ld0;
		logic       ld1;
	} crxh_top_t;

	crxh_top_t st_q, st_d;
	logic [7:0] hdr [2][5];
	logic       load [2];

	assign load[0] = load_buf0;
	assign load[1] = load_buf1;

	// one header slot per receive buffer
	for (genvar b = 0; b < 2; b++) begin : g_slot
		crxh_slot u_slot (
			.core_clk            (core_clk),
			.rst_b               (rst_b),
			.clk_en              (clk_en),
			.load                (load[b]),
			.standard_identifier (standard_identifier),
			.extended_identifier (extended_identifier),
			.ide                 (ide),
			.rtr                 (rtr),
			.reserved_ctrl_hi    (reserved_ctrl_hi),
			.reserved_ctrl_lo    (reserved_ctrl_lo),
			.dlc                 (dlc),
			.std_high            (hdr[b][0]),
			.std_low             (hdr[b][1]),
			.ext_high            (hdr[b][2]),
			.ext_low             (hdr[b][3]),
			.len_code            (hdr[b][4])
		);
	end

	// address decode and one-wait-state answer
	always_comb begin
		logic [7:0] sel;
		sel = crxh_pkg::RDATA_RST;
		unique case (avs_address)
			crxh_pkg::RX0_STD_ID_HIGH: sel = hdr[0][0];
			crxh_pkg::RX0_STD_ID_LOW:  sel = hdr[0][1];
			crxh_pkg::RX0_EXT_ID_HIGH: sel = hdr[0][2];
			crxh_pkg::RX0_EXT_ID_LOW:  sel = hdr[0][3];
			crxh_pkg::RX0_LENGTH_CODE: sel = hdr[0][4];
			crxh_pkg::RX1_STD_ID_HIGH: sel = hdr[1][0];
			crxh_pkg::RX1_STD_ID_LOW:  sel = hdr[1][1];
			crxh_pkg::RX1_EXT_ID_HIGH: sel = hdr[1][2];
			crxh_pkg::RX1_EXT_ID_LOW:  sel = hdr[1][3];
			crxh_pkg::RX1_LENGTH_CODE: sel = hdr[1][4];
			default:                   sel = crxh_pkg::RDATA_RST; // unmapped reads zero
		endcase
		st_d = st_q;
		st_d.ack = 1'b0;
		st_d.wait_n = 1'b0;
		if ((avs_read || avs_write) && !st_q.ack) begin
			st_d.ack = 1'b1;
			st_d.wait_n = 1'b1;
			st_d.rdata = avs_read ? sel : crxh_pkg::RDATA_RST; // writes ignored
		end
		// per-buffer load seen since last read of its length code
		if (st_q.ack && avs_read && avs_address == crxh_pkg::RX0_LENGTH_CODE)
			st_d.ld0 = 1'b0;
		if (st_q.ack && avs_read && avs_address == crxh_pkg::RX1_LENGTH_CODE)
			st_d.ld1 = 1'b0;
		if (load_buf0)
			st_d.ld0 = 1'b1; // set wins over clear
		if (load_buf1)
			st_d.ld1 = 1'b1;
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '{rdata: crxh_pkg::RDATA_RST, wait_n: 1'b0, ack: 1'b0,
				ld0: 1'b0, ld1: 1'b0};
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign avs_readdata    = st_q.rdata;
	assign avs_waitrequest = ~st_q.wait_n;
	assign buf0_loaded     = st_q.ld0;
	assign buf1_loaded     = st_q.ld1;
endmodule : crxh_top
`default_nettype wire

// [tb/crxh_checker.sv]
// crxh_checker: bus timing and read-back relations at the top ports.
// assumes a byte-wide Avalon-MM slave and one clock domain.
`timescale 1ns/1ns
`default_nettype none
module crxh_checker (
	input wire logic       core_clk,
	input wire logic       rst_b,
	input wire logic [7:0] avs_address,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic [7:0] avs_readdata,
	input wire logic       avs_waitrequest,
	input wire logic       load_buf0,
	input wire logic       buf0_loaded
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic       done;
	logic [7:0] lo;
	// completed read, address folded onto buffer zero
	assign done = avs_read && !avs_waitrequest;
	assign lo = avs_address & 8'hef;
	property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_one: assert property (p_one) else $error("answer too long");
	property p_hold; avs_waitrequest && !avs_read && !avs_write |=> $stable(avs_readdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_map; done && (lo < 8'h61 || lo > 8'h65) |-> avs_readdata == 8'h00; endproperty
	a_map: assert property (p_map) else $error("unmapped not zero");
	property p_z2; done && lo == 8'h62 |-> !avs_readdata[2]; endproperty
	a_z2: assert property (p_z2) else $error("id low bit 2 set");
	property p_z7; done && lo == 8'h65 |-> !avs_readdata[7]; endproperty
	a_z7: assert property (p_z7) else $error("length bit 7 set");
	property p_srr; done && lo == 8'h62 && avs_readdata[3] |-> !avs_readdata[4]; endproperty
	a_srr: assert property (p_srr) else $error("remote flag with ext");
	property p_ld; load_buf0 |=> buf0_loaded; endproperty
	a_ld: assert property (p_ld) else $error("load not seen");
endmodule : crxh_checker
bind crxh_top crxh_checker i_crxh_checker (.core_clk, .rst_b, .avs_address, .avs_read,
	.avs_write, .avs_readdata, .avs_waitrequest, .load_buf0, .buf0_loaded);
`default_nettype wire

// [tb/crxh_src.sv]
// crxh_src: receive path model, pulses one load with a frame header.
// assumes send is called just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module crxh_src (
	input  wire logic        core_clk,
	output logic      [1:0]  load,
	output logic      [36:0] hdr
);
	initial begin
		load = 2'h0;
		hdr = 37'h0;
	end
	// one-cycle pulse, then header lines scrambled
	task send(input int b, input logic [36:0] f);
		load[b] <= 1'b1;
		hdr <= f;
		@(posedge core_clk);
		load <= 2'h0;
		hdr <= ~f;
	endtask : send
endmodule : crxh_src
`default_nettype wire

// [tb/testbench.sv]
// testbench: random frame headers stored and read back over the bus.
// assumes one clock with clk_en held high.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [7:0]  avs_writedata = 8'h00;
	logic [7:0]  avs_readdata;
	logic        avs_waitrequest;
	logic [1:0]  load;
	logic [1:0]  loaded;
	logic [36:0] hdr;
	logic [36:0] last [2];
	logic [36:0] f;
	logic [7:0]  d;
	int          fails = 0;
	int          cmp_count = 0;
	integer      seed = 32'ha6f2;
	always #50 core_clk = ~core_clk;
	crxh_src i_crxh_src (.core_clk, .load, .hdr);
	crxh_top i_crxh_top (.core_clk, .rst_b, .clk_en(1'b1), .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .load_buf0(load[0]),
		.load_buf1(load[1]), .standard_identifier(hdr[36:26]), .extended_identifier(hdr[25:8]),
		.ide(hdr[7]), .rtr(hdr[6]), .reserved_ctrl_hi(hdr[5]), .reserved_ctrl_lo(hdr[4]),
		.dlc(hdr[3:0]), .buf0_loaded(loaded[0]), .buf1_loaded(loaded[1]));
	// expected byte of header register r for frame h
	function automatic logic [7:0] exp_reg(input logic [36:0] h, input int r);
		case (r)
			0: return h[36:29];
			1: return {h[28:26], h[6] & ~h[7], h[7], 1'b0, h[25:24]};
			2: return h[23:16];
			3: return h[15:8];
			default: return {1'b0, h[6] & h[7], h[5:0]};
		endcase
	endfunction : exp_reg
	task print_verdict;
		$display("fails %0d cmp_count %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	// one bus cycle, held until waitrequest is sampled low
	task bus(input logic w, input logic [7:0] a);
		int n;
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= 8'($random(seed));
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 20) begin
			fails++;
			print_verdict();
		end
	endtask : bus
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// reset values, then frames into alternating buffers
	initial begin
		last[0] = 37'h0;
		last[1] = 37'h0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 13; i++) begin
			if (i > 0) begin
				f = 37'({$random(seed), $random(seed)});
				if (i < 9) f[7:6] = i[2:1];
				@(posedge core_clk);
				i_crxh_src.send(i % 2, f);
				last[i % 2] = f;
				bus(1'b1, crxh_pkg::RX0_STD_ID_LOW + 8'(i % 2 * 16));
			end
			chk("loaded", (i > 0) ? 8'(1 << (i % 2)) : 8'h00, {6'h0, loaded});
			for (int j = 0; j < 10; j++) begin
				bus(1'b0, crxh_pkg::RX0_STD_ID_HIGH + 8'(j / 5 * 16 + j % 5));
				chk("header", exp_reg(last[j / 5], j % 5), d);
			end
			bus(1'b0, 8'h66 + 8'(i % 2 * 16));
			chk("unmapped", 8'h00, d);
			chk("cleared", 8'h00, {6'h0, loaded});
		end
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
